// ### bldc_constant_off_time_pwm.sv
// Constant off-time current chopper and bridge switch sequencer, three legs.
// Assumes comparator, rotor sensors, enable and overcurrent arrive as async pins.
`timescale 1ns/1ns
module bldc_constant_off_time_pwm #(
  parameter int OFF_CYC = (bldc_pwm_pkg::OFF_INTERVAL_NS * bldc_pwm_pkg::CLK_MHZ) / 1000
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic enable_in,
  input wire logic sense_above_ref,
  input wire logic rotor_sensor_1,
  input wire logic rotor_sensor_2,
  input wire logic rotor_sensor_3,
  input wire logic direction_select,
  input wire logic overcurrent_in,
  output logic [2:0] gate_hi,
  output logic [2:0] gate_lo,
  output logic pump_oscillator_out,
  output logic fault_flag_out,
  output logic fault_flag_oe_n
);
  localparam logic [15:0] DT = 16'(bldc_pwm_pkg::LEG_DEADTIME_CYC);
  localparam logic [15:0] MASK = 16'(bldc_pwm_pkg::MASK_TIME_CYC);
  localparam logic [15:0] MINON = 16'(bldc_pwm_pkg::MIN_ON_CYC);
  localparam logic [15:0] RCR = 16'(bldc_pwm_pkg::RC_RECHARGE_CYC);
  localparam logic [15:0] PHALF = 16'(bldc_pwm_pkg::PUMP_HALF_CYC);
  localparam logic [15:0] OFFC = 16'(OFF_CYC);

  logic [6:0] pins_sync;
  logic en_s, cmp_s, dir_s, ocd_s;
  logic [2:0] hall_s;
  bldc_pwm_pkg::seq_state_t state_reg;
  logic [3:0] pat_reg, pat_now;
  logic [15:0] tmr_reg, off_reg, on_cnt_reg, rc_reg, pump_cnt_reg, off_load;
  logic trig, pat_chg;

  pin_sync #(.W(7)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in({enable_in, sense_above_ref, direction_select, overcurrent_in,
               rotor_sensor_1, rotor_sensor_2, rotor_sensor_3}),
    .sync_out(pins_sync)
  );
  assign {en_s, cmp_s, dir_s, ocd_s, hall_s} = pins_sync;

  // Rotor code to {source leg, sink leg}; reverse swaps the two roles
  function automatic logic [3:0] leg_decode(input logic [2:0] h, input logic fwd);
    logic [3:0] p;
    p = 4'h0;
    case (h)
      3'h4: p = {2'h0, 2'h2};
      3'h6: p = {2'h1, 2'h2};
      3'h2, 3'h7: p = {2'h1, 2'h0};
      3'h3: p = {2'h2, 2'h0};
      3'h1: p = {2'h2, 2'h1};
      default: p = {2'h0, 2'h1};
    endcase
    return fwd ? p : {p[1:0], p[3:2]};
  endfunction : leg_decode

  assign pat_now = leg_decode(hall_s, dir_s);
  assign pat_chg = pat_now != pat_reg;
  // Trip only after the mask and the minimum on time have run out
  assign trig = cmp_s && on_cnt_reg >= MASK && on_cnt_reg >= MINON;
  // Uncharged timing element shortens the next off interval
  assign off_load = (rc_reg >= OFFC) ? 16'h0001 : OFFC - rc_reg;

  // Sequencer; any commutation or disable passes through all-off for a deadtime
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= bldc_pwm_pkg::S_IDLE;
      tmr_reg <= DT;
      off_reg <= 16'h0000;
      on_cnt_reg <= 16'h0000;
      pat_reg <= 4'h1;
    end else if (!en_s || (pat_chg && state_reg != bldc_pwm_pkg::S_IDLE)) begin
      state_reg <= bldc_pwm_pkg::S_IDLE;
      tmr_reg <= DT;
      off_reg <= 16'h0000;
    end else begin
      case (state_reg)
        bldc_pwm_pkg::S_IDLE: begin
          pat_reg <= pat_now;
          if (pat_chg) begin
            tmr_reg <= DT;
          end else if (tmr_reg == 16'h0000) begin
            state_reg <= bldc_pwm_pkg::S_ON;
            on_cnt_reg <= 16'h0000;
          end else begin
            tmr_reg <= tmr_reg - 16'h0001;
          end
        end
        bldc_pwm_pkg::S_ON: begin
          if (on_cnt_reg < MINON || on_cnt_reg < MASK) begin
            on_cnt_reg <= on_cnt_reg + 16'h0001;
          end
          if (trig) begin
            state_reg <= bldc_pwm_pkg::S_DT_OFF;
            tmr_reg <= DT;
            off_reg <= off_load;
          end
        end
        bldc_pwm_pkg::S_DT_OFF, bldc_pwm_pkg::S_SYNC: begin
          off_reg <= off_reg - 16'h0001;
          tmr_reg <= (tmr_reg == 16'h0000) ? 16'h0000 : tmr_reg - 16'h0001;
          if (off_reg == 16'h0001) begin
            state_reg <= bldc_pwm_pkg::S_DT_ON;
            tmr_reg <= DT;
          end else if (state_reg == bldc_pwm_pkg::S_DT_OFF && tmr_reg == 16'h0000) begin
            state_reg <= bldc_pwm_pkg::S_SYNC;
          end
        end
        bldc_pwm_pkg::S_DT_ON: begin
          if (tmr_reg == 16'h0000) begin
            state_reg <= bldc_pwm_pkg::S_ON;
            on_cnt_reg <= 16'h0000;
          end else begin
            tmr_reg <= tmr_reg - 16'h0001;
          end
        end
        default: begin
          state_reg <= bldc_pwm_pkg::S_IDLE;
          tmr_reg <= DT;
        end
      endcase
    end
  end

  // Timing element recharges after each off interval ends
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rc_reg <= 16'h0000;
    end else if ((state_reg == bldc_pwm_pkg::S_SYNC || state_reg == bldc_pwm_pkg::S_DT_OFF)
                 && off_reg == 16'h0001) begin
      // A short off that never reached rectification still recharges the element
      rc_reg <= RCR;
    end else if (rc_reg != 16'h0000) begin
      rc_reg <= rc_reg - 16'h0001;
    end
  end

  // Gate drive: source upper held, sink alternates lower and upper
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gate_hi <= 3'h0;
      gate_lo <= 3'h0;
    end else begin
      gate_hi <= 3'h0;
      gate_lo <= 3'h0;
      if (state_reg != bldc_pwm_pkg::S_IDLE) begin
        gate_hi[pat_reg[3:2]] <= 1'b1;
      end
      if (state_reg == bldc_pwm_pkg::S_ON) begin
        gate_lo[pat_reg[1:0]] <= 1'b1;
      end
      if (state_reg == bldc_pwm_pkg::S_SYNC) begin
        gate_hi[pat_reg[1:0]] <= 1'b1;
      end
    end
  end

  // Free-running pump oscillator, independent of enable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pump_cnt_reg <= 16'h0000;
      pump_oscillator_out <= 1'b0;
    end else if (pump_cnt_reg == PHALF - 16'h0001) begin
      pump_cnt_reg <= 16'h0000;
      pump_oscillator_out <= ~pump_oscillator_out;
    end else begin
      pump_cnt_reg <= pump_cnt_reg + 16'h0001;
    end
  end

  // Open-drain fault: drive low while overcurrent is seen
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_flag_out <= 1'b0;
      fault_flag_oe_n <= 1'b1;
    end else begin
      fault_flag_out <= 1'b0;
      fault_flag_oe_n <= ~ocd_s;
    end
  end

  // Per-leg count of cycles with both switches off, for the deadtime check
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_leg
      // One counter per leg keeps each process the only writer of its variable
      logic [15:0] quiet_reg;
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          quiet_reg <= 16'hffff;
        end else if (gate_hi[g] || gate_lo[g]) begin
          quiet_reg <= 16'h0000;
        end else if (quiet_reg != 16'hffff) begin
          quiet_reg <= quiet_reg + 16'h0001;
        end
      end
      a_leg_deadtime: assert property (@(posedge clk_sys) disable iff (rst)
        ($rose(gate_hi[g]) || $rose(gate_lo[g])) |-> $past(quiet_reg) >= DT - 16'h0001
        && !(gate_hi[g] && gate_lo[g])) else $error("Leg switched without deadtime");
    end
  endgenerate

  a_trip_starts_off: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == bldc_pwm_pkg::S_ON && trig && en_s && !pat_chg
    |=> state_reg == bldc_pwm_pkg::S_DT_OFF ##1 gate_lo == 3'h0)
    else $error("Comparator trip did not start off phase");
  a_off_expiry: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == bldc_pwm_pkg::S_SYNC && off_reg == 16'h0001 && en_s && !pat_chg
    |=> state_reg == bldc_pwm_pkg::S_DT_ON) else $error("Off timer expiry ignored");
  a_reon_delay: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(state_reg == bldc_pwm_pkg::S_DT_ON) |-> tmr_reg == DT
    && gate_lo == 3'h0) else $error("Turn-on not delayed by deadtime");
  a_mask_window: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == bldc_pwm_pkg::S_ON && on_cnt_reg < MASK
    |=> state_reg != bldc_pwm_pkg::S_DT_OFF) else $error("Trip inside mask window");
  a_min_on: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == bldc_pwm_pkg::S_ON && on_cnt_reg < MINON
    |=> state_reg != bldc_pwm_pkg::S_DT_OFF) else $error("On phase below minimum");
  a_short_off: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(state_reg == bldc_pwm_pkg::S_DT_OFF) |-> off_reg >= 16'h0001 && off_reg <= OFFC)
    else $error("Off interval load out of range");
  a_two_legs: assert property (@(posedge clk_sys) disable iff (rst)
    $countones(gate_hi | gate_lo) <= 2) else $error("Third leg active");
  a_sync_rect: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == bldc_pwm_pkg::S_SYNC && $past(state_reg == bldc_pwm_pkg::S_SYNC)
    |=> $countones(gate_hi) == 2) else $error("Rectifier upper not on");
  a_pump_toggle: assert property (@(posedge clk_sys) disable iff (rst)
    pump_cnt_reg == PHALF - 16'h0001 |=> $changed(pump_oscillator_out)
    ##1 $stable(pump_oscillator_out)) else $error("Pump oscillator stalled");
  a_fault_drive: assert property (@(posedge clk_sys) disable iff (rst)
    ocd_s |=> !fault_flag_oe_n && !fault_flag_out) else $error("Fault output not pulled low");
  a_disable_off: assert property (@(posedge clk_sys) disable iff (rst)
    !en_s |=> ##1 gate_hi == 3'h0 && gate_lo == 3'h0) else $error("Bridge on while disabled");

  c_trip: cover property (@(posedge clk_sys) disable iff (rst)
    state_reg == bldc_pwm_pkg::S_ON ##1 state_reg == bldc_pwm_pkg::S_DT_OFF);
  c_sync: cover property (@(posedge clk_sys) disable iff (rst)
    state_reg == bldc_pwm_pkg::S_SYNC ##1 state_reg == bldc_pwm_pkg::S_DT_ON);
  c_short_off: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(state_reg == bldc_pwm_pkg::S_DT_OFF) && rc_reg != 16'h0000);
  c_commutate: cover property (@(posedge clk_sys) disable iff (rst)
    state_reg == bldc_pwm_pkg::S_ON && pat_chg && en_s);
endmodule : bldc_constant_off_time_pwm

// ### bldc_pwm_pkg.sv
// Shared constants and types for the constant off-time bridge controller.
// Assumes a 250 MHz system clock; every timing count except the off interval is derived from it here.
package bldc_pwm_pkg;
  localparam int CLK_MHZ = 250;
  // Printed times in nanoseconds, pump frequency in kilohertz
  localparam int LEG_DEADTIME_NS = 1000;
  localparam int COMPARATOR_MASK_TIME_NS = 1000;
  localparam int MINIMUM_ON_INTERVAL_NS = 1500;
  localparam int OFF_INTERVAL_NS = 13000;
  localparam int RC_RECHARGE_NS = 600;
  localparam int PUMP_FREQ_KHZ = 600;
  // Counts of clock cycles; least times round up, half period rounds down
  localparam int LEG_DEADTIME_CYC = (LEG_DEADTIME_NS * CLK_MHZ + 999) / 1000;
  localparam int MASK_TIME_CYC = (COMPARATOR_MASK_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int MIN_ON_CYC = (MINIMUM_ON_INTERVAL_NS * CLK_MHZ + 999) / 1000;
  localparam int RC_RECHARGE_CYC = (RC_RECHARGE_NS * CLK_MHZ + 999) / 1000;
  localparam int PUMP_HALF_CYC = (CLK_MHZ * 1000) / (2 * PUMP_FREQ_KHZ);
  localparam int CNT_W = 16;
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_ON = 5'h02,
    S_DT_OFF = 5'h04,
    S_SYNC = 5'h08,
    S_DT_ON = 5'h10
  } seq_state_t;
endpackage : bldc_pwm_pkg

// ### pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes each bit is an independent level; no bus coherency is promised.
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : pin_sync

// ### winding_model.sv
// Far side: motor winding and sense resistor seen through the comparator.
// Assumes registered gates on clk_sys; mode 0 low, 1 stuck high, 2 real ramp.
`timescale 1ns/1ns
module winding_model (
  input wire logic clk_sys,
  input wire logic [2:0] gate_hi,
  input wire logic [2:0] gate_lo,
  input wire logic [1:0] mode,
  output logic sense_above_ref
);
  int current = 0;
  // Current rises only while a source upper and a sink lower conduct
  always @(posedge clk_sys) begin
    if (gate_hi != 3'h0 && gate_lo != 3'h0) current <= current + 3;
    else if (current > 0) current <= current - 1;
  end
  // Stuck-high mode shows the recovery spike the mask must hide
  assign sense_above_ref = (mode == 2'h1) || (mode == 2'h2 && current > 600);
endmodule : winding_model

// ### bldc_constant_off_time_pwm_bench.sv
// Self-checking bench for the off-time chopper and bridge sequencer.
// Assumes winding_model on the far side and a shortened off timer.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module bldc_constant_off_time_pwm_bench;
  localparam int OFF = 1000;
  localparam int DT = bldc_pwm_pkg::LEG_DEADTIME_CYC;
  logic clk_sys = 0, rst = 1, enable_in = 0, sense_above_ref;
  logic rotor_sensor_1 = 0, rotor_sensor_2 = 0, rotor_sensor_3 = 0;
  logic direction_select = 1, overcurrent_in = 0;
  logic [2:0] gate_hi, gate_lo;
  logic pump_oscillator_out, fault_flag_out, fault_flag_oe_n;
  logic [1:0] mode = 2'h0;
  int num_errors = 0, num_checks = 0, cyc = 0, t0, t1, t2, t3, t4, i;
  logic [2:0] code;
  logic [5:0] last_pat = 6'h00;
  logic p;
  initial forever #2 clk_sys = ~clk_sys;
  bldc_constant_off_time_pwm #(.OFF_CYC(OFF)) uut (.clk_sys(clk_sys), .rst(rst),
    .enable_in(enable_in), .sense_above_ref(sense_above_ref),
    .rotor_sensor_1(rotor_sensor_1), .rotor_sensor_2(rotor_sensor_2),
    .rotor_sensor_3(rotor_sensor_3), .direction_select(direction_select),
    .overcurrent_in(overcurrent_in), .gate_hi(gate_hi), .gate_lo(gate_lo),
    .pump_oscillator_out(pump_oscillator_out), .fault_flag_out(fault_flag_out),
    .fault_flag_oe_n(fault_flag_oe_n));
  winding_model far_side (.clk_sys(clk_sys), .gate_hi(gate_hi), .gate_lo(gate_lo),
    .mode(mode), .sense_above_ref(sense_above_ref));
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // Reference decoder: sensor code to source upper and sink lower
  function automatic logic [5:0] model_gates(input logic [2:0] c, input logic fwd);
    int src, snk;
    case (c)
      3'h4: begin src = 0; snk = 2; end
      3'h6: begin src = 1; snk = 2; end
      3'h2, 3'h7: begin src = 1; snk = 0; end
      3'h3: begin src = 2; snk = 0; end
      3'h1: begin src = 2; snk = 1; end
      default: begin src = 0; snk = 1; end
    endcase
    return fwd ? {3'h1 << src, 3'h1 << snk} : {3'h1 << snk, 3'h1 << src};
  endfunction : model_gates
  function automatic bit cond(input int k);
    case (k)
      0: return gate_lo === 3'h0;
      1: return $countones(gate_hi) == 2;
      2: return $countones(gate_hi) == 1;
      default: return gate_lo !== 3'h0;
    endcase
  endfunction : cond
  // Polls at the falling edge so registered gates have settled
  task wait_cond(input int k, output int t);
    while (!cond(k)) @(negedge clk_sys);
    t = cyc;
  endtask : wait_cond
  task set_code(input logic [2:0] c, input logic fwd);
    {rotor_sensor_1, rotor_sensor_2, rotor_sensor_3} = c;
    direction_select = fwd;
    repeat (6) @(negedge clk_sys);
    // A new code that maps to the same legs leaves the bridge running
    `CHK("change_off", (model_gates(c, fwd) == last_pat) ? last_pat : 6'h00, {gate_hi, gate_lo})
    repeat (260) @(negedge clk_sys);
    `CHK("pattern", model_gates(c, fwd), {gate_hi, gate_lo})
    last_pat = model_gates(c, fwd);
  endtask : set_code
  // Cycle count doubles as the hang limit
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      stop_test;
    end
  end
  // Shoot-through and third-leg checks run on every settled cycle
  always @(negedge clk_sys) begin
    if (!rst) begin
      `CHK("leg_overlap", 3'h0, gate_hi & gate_lo)
      `CHK("legs_active", 1'b1, $countones(gate_hi | gate_lo) <= 2)
    end
  end
  initial begin
    void'($urandom(13));
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys) rst = 0;
    `CHK("reset_gates", 6'h00, {gate_hi, gate_lo})
    `CHK("reset_fault", 1'b1, fault_flag_oe_n)
    enable_in = 1;
    for (i = 0; i < 16; i++) set_code(i[2:0], i[3]);
    $display("test decode done");
    // Enable low mid-run must clear every switch
    enable_in = 0;
    repeat (6) @(negedge clk_sys);
    `CHK("enable_off", 6'h00, {gate_hi, gate_lo})
    enable_in = 1;
    // Bridge must come back on the unchanged pattern after one deadtime
    repeat (260) @(negedge clk_sys);
    `CHK("enable_on", last_pat, {gate_hi, gate_lo})
    $display("test enable done");
    p = pump_oscillator_out;
    while (pump_oscillator_out === p) @(negedge clk_sys);
    t0 = cyc;
    p = pump_oscillator_out;
    while (pump_oscillator_out === p) @(negedge clk_sys);
    `CHK("pump_half", bldc_pwm_pkg::PUMP_HALF_CYC, cyc - t0)
    $display("test pump done");
    overcurrent_in = 1;
    repeat (2 + $urandom % 4) @(negedge clk_sys);
    repeat (4) @(negedge clk_sys);
    `CHK("fault_low", 2'h0, {fault_flag_oe_n, fault_flag_out})
    overcurrent_in = 0;
    repeat (5) @(negedge clk_sys);
    `CHK("fault_clear", 1'b1, fault_flag_oe_n)
    $display("test fault done");
    code = 3'(1 + $urandom % 6);
    set_code(code, 1'b1);
    // Stuck-high sense: trip at once once the mask and minimum on run out
    mode = 2'h1;
    wait_cond(0, t0);
    `CHK("lower_first", 1'b1, $countones(gate_hi) == 1)
    wait_cond(1, t1);
    `CHK("rectify_wait", 1'b1, t1 - t0 >= DT)
    wait_cond(2, t2);
    wait_cond(3, t3);
    `CHK("reon_wait", 1'b1, t3 - t2 >= DT)
    `CHK("off_span", 1'b1, t3 - t0 >= OFF + DT && t3 - t0 <= OFF + DT + 2)
    wait_cond(0, t4);
    `CHK("min_on", 1'b1, t4 - t3 >= bldc_pwm_pkg::MIN_ON_CYC)
    `CHK("mask", 1'b1, t4 - t3 >= bldc_pwm_pkg::MASK_TIME_CYC)
    `CHK("trip_prompt", 1'b1, t4 - t3 <= bldc_pwm_pkg::MIN_ON_CYC + 8)
    $display("test chop done");
    mode = 2'h2;
    repeat (8000) @(negedge clk_sys);
    $display("test ramp done");
    stop_test;
  end
endmodule : bldc_constant_off_time_pwm_bench
